/* core/dcu_top.sv */
// Dual channel serial unit exchanging terminated ASCII messages
//
// Notes on behaviour
// - Two channels run independent data paths, sharing terminator and halt
// - Start-stop framing carrying ASCII characters
// - Received message raises receive-complete flag
// - Host fills buffer, sets start; then send
// - Trailing code ends message; resets to 0x0D
// - Messages up to 896 bytes with terminator
// - Only one terminator value at once
// - Three-bit code picks 300 to 19200 baud
// - Second channel has own switch set
// - Default format 8 data, odd, 1 stop, 9600
// - Transmit lamp lit while start is set or sending
// - Receive lamp lit only while receiving
// - Run lamp lit when running without fault
`timescale 1ns/1ps
`include "dcu_params.svh"

module dcu_top #(
  parameter int CLK_HZ = `DCU_CLK_HZ
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // AHB-Lite slave
  input  wire dcu_pkg::dcu_ahbReq_s ahbReq,
  input  wire logic                 hready,
  output      dcu_pkg::dcu_ahbRsp_s ahbRsp,
  output      logic                 irq,
  // Parameter switches
  input  wire logic [6:0]           ch1_param_switches,
  input  wire logic [6:0]           ch2_param_switches,
  // Serial lines
  input  wire logic                 ch1Rxd,
  input  wire logic                 ch2Rxd,
  output      logic                 ch1Txd,
  output      logic                 ch2Txd,
  // Status lamps
  output      logic                 runLed,
  output      logic                 ch1_tx_active_led,
  output      logic                 ch1_rx_active_led,
  output      logic                 ch2_tx_active_led,
  output      logic                 ch2_rx_active_led
);
  import dcu_pkg::*;

  dcu_state_s s_ff;
  dcu_state_s nxt_s;
  logic [1:0] rxdPin;
  logic [1:0][6:0] swPin;

  assign rxdPin = {ch2Rxd, ch1Rxd};
  assign swPin  = {ch2_param_switches, ch1_param_switches};

  // ==========================================================
  // Decoders
  function automatic logic [19:0] baudDiv(input logic [2:0] code);
    logic [2:0] k;
    k = (code == 3'h7) ? `DCU_BAUD_DEF_CODE : code;
    return 20'(CLK_HZ / (`DCU_BAUD_BASE << k));
  endfunction

  function automatic logic [1:0] regionOf(input logic [14:0] a);
    logic [1:0] r;
    r = a[14:13];
    if (r == `DCU_RGN_REGS) begin
      return (a[12] == 1'b0) ? `DCU_RGN_REGS : `DCU_RGN_NONE;
    end
    if ((r == `DCU_RGN_RX || r == `DCU_RGN_TX) && a[11:2] < `DCU_MSG_MAX) begin
      return r;
    end
    return `DCU_RGN_NONE;
  endfunction

  function automatic logic parityOf(input logic [7:0] d, input logic odd);
    return odd ? ~^d : ^d;
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    logic [19:0] bd;
    logic [7:0]  d;
    logic [3:0]  nb;
    logic [6:0]  sw;
    logic [31:0] rd;
    logic [14:0] a;
    bd = 20'h0;
    d = 8'h0;
    nb = 4'h0;
    sw = 7'h0;
    rd = 32'h0;
    a = ahbReq.haddr[14:0];
    nxt_s = s_ff;

    // Status clears on write of one, before events so a set wins
    if (s_ff.dpValid && s_ff.dpWrite && regionOf(s_ff.dpAddr) == `DCU_RGN_REGS
        && s_ff.dpAddr[11:0] == `DCU_REG_STATUS) begin
      nxt_s.status = s_ff.status & ~ahbReq.hwdata[5:0];
    end

    for (int c = 0; c < 2; c++) begin
      // Pin synchronisers
      nxt_s.chan[c].rxSync1 = rxdPin[c];
      nxt_s.chan[c].rxSync2 = s_ff.chan[c].rxSync1;
      nxt_s.chan[c].swSync1 = swPin[c];
      nxt_s.chan[c].swSync2 = s_ff.chan[c].swSync1;
      sw = s_ff.chan[c].swSync2;
      bd = baudDiv(sw[`DCU_SW_BAUD_LSB +: 3]);
      nb = sw[`DCU_SW_DATA8] ? 4'h8 : 4'h7;

      // Transmitter
      case (s_ff.chan[c].txSt)
        SER_IDLE: begin
          nxt_s.chan[c].txd = 1'b1;
          if (s_ff.txGo[c] && !s_ff.halt) begin
            d = s_ff.txBuf[c][s_ff.chan[c].txIdx];
            if (!sw[`DCU_SW_DATA8]) begin
              d[7] = 1'b0;
            end
            nxt_s.chan[c].txSh  = d;
            nxt_s.chan[c].txPar = parityOf(d, sw[`DCU_SW_PAR_ODD]);
            nxt_s.chan[c].txDiv = bd - 20'h1;
            nxt_s.chan[c].txd   = 1'b0;
            nxt_s.chan[c].txSt  = SER_START;
          end
        end
        SER_START: begin
          nxt_s.chan[c].txDiv = s_ff.chan[c].txDiv - 20'h1;
          if (s_ff.chan[c].txDiv == 20'h0) begin
            nxt_s.chan[c].txDiv = bd - 20'h1;
            nxt_s.chan[c].txBit = 4'h0;
            nxt_s.chan[c].txd   = s_ff.chan[c].txSh[0];
            nxt_s.chan[c].txSt  = SER_DATA;
          end
        end
        SER_DATA: begin
          nxt_s.chan[c].txDiv = s_ff.chan[c].txDiv - 20'h1;
          if (s_ff.chan[c].txDiv == 20'h0) begin
            nxt_s.chan[c].txDiv = bd - 20'h1;
            nxt_s.chan[c].txSh  = s_ff.chan[c].txSh >> 1;
            nxt_s.chan[c].txd   = s_ff.chan[c].txSh[1];
            nxt_s.chan[c].txBit = s_ff.chan[c].txBit + 4'h1;
            if (s_ff.chan[c].txBit == nb - 4'h1) begin
              nxt_s.chan[c].txBit = 4'h0;
              if (sw[`DCU_SW_PAR_EN]) begin
                nxt_s.chan[c].txd  = s_ff.chan[c].txPar;
                nxt_s.chan[c].txSt = SER_PAR;
              end else begin
                nxt_s.chan[c].txd  = 1'b1;
                nxt_s.chan[c].txSt = SER_STOP;
              end
            end
          end
        end
        SER_PAR: begin
          nxt_s.chan[c].txDiv = s_ff.chan[c].txDiv - 20'h1;
          if (s_ff.chan[c].txDiv == 20'h0) begin
            nxt_s.chan[c].txDiv = bd - 20'h1;
            nxt_s.chan[c].txd   = 1'b1;
            nxt_s.chan[c].txSt  = SER_STOP;
          end
        end
        SER_STOP: begin
          nxt_s.chan[c].txDiv = s_ff.chan[c].txDiv - 20'h1;
          if (s_ff.chan[c].txDiv == 20'h0) begin
            nxt_s.chan[c].txDiv = bd - 20'h1;
            nxt_s.chan[c].txBit = s_ff.chan[c].txBit + 4'h1;
            if (s_ff.chan[c].txBit == {3'h0, sw[`DCU_SW_STOP2]}) begin
              nxt_s.chan[c].txSt = SER_IDLE;
              nxt_s.chan[c].txIdx = s_ff.chan[c].txIdx + 10'h1;
              d = s_ff.txBuf[c][s_ff.chan[c].txIdx];
              if (d == s_ff.term || s_ff.chan[c].txIdx == `DCU_MSG_MAX - 10'h1) begin
                nxt_s.chan[c].txIdx = 10'h0;
                nxt_s.txGo[c] = 1'b0;
                nxt_s.status[`DCU_ST_TXDONE + c] = 1'b1;
              end
            end
          end
        end
        default: begin
          nxt_s.chan[c].txSt = SER_IDLE;
        end
      endcase

      // Receiver
      case (s_ff.chan[c].rxSt)
        SER_IDLE: begin
          if (!s_ff.chan[c].rxSync2) begin
            nxt_s.chan[c].rxDiv = (bd >> 1) - 20'h1;
            nxt_s.chan[c].rxSt  = SER_START;
          end
        end
        SER_START: begin
          nxt_s.chan[c].rxDiv = s_ff.chan[c].rxDiv - 20'h1;
          if (s_ff.chan[c].rxDiv == 20'h0) begin
            nxt_s.chan[c].rxDiv = bd - 20'h1;
            nxt_s.chan[c].rxBit = 4'h0;
            nxt_s.chan[c].rxSh  = 8'h0;
            nxt_s.chan[c].rxSt  = s_ff.chan[c].rxSync2 ? SER_IDLE : SER_DATA;
          end
        end
        SER_DATA: begin
          nxt_s.chan[c].rxDiv = s_ff.chan[c].rxDiv - 20'h1;
          if (s_ff.chan[c].rxDiv == 20'h0) begin
            nxt_s.chan[c].rxDiv = bd - 20'h1;
            nxt_s.chan[c].rxSh[s_ff.chan[c].rxBit[2:0]] = s_ff.chan[c].rxSync2;
            nxt_s.chan[c].rxBit = s_ff.chan[c].rxBit + 4'h1;
            if (s_ff.chan[c].rxBit == nb - 4'h1) begin
              nxt_s.chan[c].rxSt = sw[`DCU_SW_PAR_EN] ? SER_PAR : SER_STOP;
            end
          end
        end
        SER_PAR: begin
          nxt_s.chan[c].rxDiv = s_ff.chan[c].rxDiv - 20'h1;
          if (s_ff.chan[c].rxDiv == 20'h0) begin
            nxt_s.chan[c].rxDiv = bd - 20'h1;
            nxt_s.chan[c].rxPar = s_ff.chan[c].rxSync2;
            nxt_s.chan[c].rxSt  = SER_STOP;
          end
        end
        SER_STOP: begin
          nxt_s.chan[c].rxDiv = s_ff.chan[c].rxDiv - 20'h1;
          if (s_ff.chan[c].rxDiv == 20'h0) begin
            nxt_s.chan[c].rxSt = SER_IDLE;
            d = s_ff.chan[c].rxSh;
            if (!s_ff.chan[c].rxSync2 || (sw[`DCU_SW_PAR_EN]
                && s_ff.chan[c].rxPar != parityOf(d, sw[`DCU_SW_PAR_ODD]))) begin
              nxt_s.status[`DCU_ST_RXERR + c] = 1'b1;
            end else if (s_ff.status[`DCU_ST_RXDONE + c]) begin
              nxt_s.status[`DCU_ST_RXERR + c] = 1'b1;
            end else begin
              nxt_s.rxBuf[c][s_ff.chan[c].rxIdx] = d;
              nxt_s.chan[c].rxIdx = s_ff.chan[c].rxIdx + 10'h1;
              if (d == s_ff.term) begin
                nxt_s.status[`DCU_ST_RXDONE + c] = 1'b1;
                nxt_s.chan[c].rxLen = s_ff.chan[c].rxIdx + 10'h1;
                nxt_s.chan[c].rxIdx = 10'h0;
              end else if (s_ff.chan[c].rxIdx == `DCU_MSG_MAX - 10'h1) begin
                nxt_s.status[`DCU_ST_RXERR + c] = 1'b1;
                nxt_s.chan[c].rxIdx = 10'h0;
              end
            end
          end
        end
        default: begin
          nxt_s.chan[c].rxSt = SER_IDLE;
        end
      endcase

      nxt_s.chan[c].txLed = nxt_s.txGo[c] || nxt_s.chan[c].txSt != SER_IDLE;
      nxt_s.chan[c].rxLed = nxt_s.chan[c].rxSt != SER_IDLE;
    end

    // Data phase writes
    if (s_ff.dpValid && s_ff.dpWrite) begin
      case (regionOf(s_ff.dpAddr))
        `DCU_RGN_REGS: begin
          case (s_ff.dpAddr[11:0])
            `DCU_REG_CTRL: begin
              nxt_s.halt = ahbReq.hwdata[`DCU_CT_HALT];
              nxt_s.txGo = nxt_s.txGo | ahbReq.hwdata[`DCU_CT_TXGO +: 2];
            end
            `DCU_REG_MASK: begin
              nxt_s.mask = ahbReq.hwdata[5:0];
            end
            `DCU_REG_TERM: begin
              nxt_s.term = ahbReq.hwdata[7:0];
            end
            default: begin
              nxt_s.term = nxt_s.term;
            end
          endcase
        end
        `DCU_RGN_TX: begin
          nxt_s.txBuf[s_ff.dpAddr[12]][s_ff.dpAddr[11:2]] = ahbReq.hwdata[7:0];
        end
        default: begin
          nxt_s.term = nxt_s.term;
        end
      endcase
    end

    // Address phase capture and read data
    nxt_s.dpValid = hready && ahbReq.hsel && ahbReq.htrans[1];
    if (nxt_s.dpValid) begin
      nxt_s.dpWrite = ahbReq.hwrite;
      nxt_s.dpAddr  = a;
      case (regionOf(a))
        `DCU_RGN_REGS: begin
          case (a[11:0])
            `DCU_REG_CTRL: begin
              rd[`DCU_CT_HALT] = s_ff.halt;
              rd[`DCU_CT_TXGO +: 2] = s_ff.txGo;
            end
            `DCU_REG_STATUS: rd[5:0] = s_ff.status;
            `DCU_REG_MASK:   rd[5:0] = s_ff.mask;
            `DCU_REG_TERM:   rd[7:0] = s_ff.term;
            `DCU_REG_RXLEN0: rd[9:0] = s_ff.chan[0].rxLen;
            `DCU_REG_RXLEN1: rd[9:0] = s_ff.chan[1].rxLen;
            `DCU_REG_SWITCH: begin
              rd[6:0] = s_ff.chan[0].swSync2;
              rd[`DCU_SW2_LSB +: 7] = s_ff.chan[1].swSync2;
            end
            default: rd = 32'h0;
          endcase
        end
        `DCU_RGN_RX: rd[7:0] = s_ff.rxBuf[a[12]][a[11:2]];
        `DCU_RGN_TX: rd[7:0] = s_ff.txBuf[a[12]][a[11:2]];
        default:     rd = 32'h0;
      endcase
      nxt_s.rdata = rd;
    end

    nxt_s.readyOut = 1'b1;
    nxt_s.resp     = 1'b0;
    nxt_s.irq      = |(nxt_s.status & nxt_s.mask);
    nxt_s.runLed   = !nxt_s.halt && !(|nxt_s.status[`DCU_ST_RXERR +: 2]);
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff          <= '0;
      s_ff.term     <= `DCU_TERM_RST;
      s_ff.readyOut <= 1'b1;
      s_ff.runLed   <= 1'b1;
      for (int c = 0; c < 2; c++) begin
        s_ff.chan[c].txd     <= 1'b1;
        s_ff.chan[c].rxSync1 <= 1'b1;
        s_ff.chan[c].rxSync2 <= 1'b1;
      end
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================================
  // Outputs
  assign ahbRsp            = '{hrdata: s_ff.rdata, hreadyout: s_ff.readyOut, hresp: s_ff.resp};
  assign irq               = s_ff.irq;
  assign ch1Txd            = s_ff.chan[0].txd;
  assign ch2Txd            = s_ff.chan[1].txd;
  assign runLed            = s_ff.runLed;
  assign ch1_tx_active_led = s_ff.chan[0].txLed;
  assign ch1_rx_active_led = s_ff.chan[0].rxLed;
  assign ch2_tx_active_led = s_ff.chan[1].txLed;
  assign ch2_rx_active_led = s_ff.chan[1].rxLed;

endmodule

/* core/dcu_params.svh */
// Constants for the dual channel message serial unit
`ifndef DCU_PARAMS_SVH
`define DCU_PARAMS_SVH

// ==========================================================
// Clock and timing
`define DCU_CLK_HZ        200000000
`define DCU_BAUD_BASE     300
`define DCU_BAUD_DEF_CODE 3'h5

// ==========================================================
// Message limits
`define DCU_MSG_MAX       10'd896
`define DCU_TERM_RST      8'h0D

// ==========================================================
// Switch fields
`define DCU_SW_BAUD_LSB   0
`define DCU_SW_PAR_EN     3
`define DCU_SW_PAR_ODD    4
`define DCU_SW_DATA8      5
`define DCU_SW_STOP2      6

// ==========================================================
// Register offsets
`define DCU_REG_CTRL      12'h000
`define DCU_REG_STATUS    12'h004
`define DCU_REG_MASK      12'h008
`define DCU_REG_TERM      12'h00C
`define DCU_REG_RXLEN0    12'h010
`define DCU_REG_RXLEN1    12'h014
`define DCU_REG_SWITCH    12'h018

// ==========================================================
// Address regions on haddr[14:13]
`define DCU_RGN_REGS      2'h0
`define DCU_RGN_RX        2'h1
`define DCU_RGN_TX        2'h2
`define DCU_RGN_NONE      2'h3

// ==========================================================
// Register fields
`define DCU_CT_TXGO       0
`define DCU_CT_HALT       4
`define DCU_ST_RXDONE     0
`define DCU_ST_TXDONE     2
`define DCU_ST_RXERR      4
`define DCU_SW2_LSB       8

`endif

/* core/dcu_pkg.sv */
// Types of the dual channel message serial unit
package dcu_pkg;
`include "dcu_params.svh"

  typedef enum logic [2:0] {
    SER_IDLE  = 3'b000,
    SER_START = 3'b001,
    SER_DATA  = 3'b011,
    SER_PAR   = 3'b010,
    SER_STOP  = 3'b110
  } dcu_ser_e;

  typedef struct packed {
    logic        hsel;
    logic [1:0]  htrans;
    logic [31:0] haddr;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
  } dcu_ahbReq_s;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } dcu_ahbRsp_s;

  typedef struct packed {
    logic       rxSync1;
    logic       rxSync2;
    logic [6:0] swSync1;
    logic [6:0] swSync2;
    dcu_ser_e   txSt;
    logic [19:0] txDiv;
    logic [3:0] txBit;
    logic [7:0] txSh;
    logic       txPar;
    logic [9:0] txIdx;
    logic       txd;
    dcu_ser_e   rxSt;
    logic [19:0] rxDiv;
    logic [3:0] rxBit;
    logic [7:0] rxSh;
    logic       rxPar;
    logic [9:0] rxIdx;
    logic [9:0] rxLen;
    logic       txLed;
    logic       rxLed;
  } dcu_chan_s;

  typedef struct packed {
    dcu_chan_s [1:0]             chan;
    logic [1:0][895:0][7:0]      rxBuf;
    logic [1:0][895:0][7:0]      txBuf;
    logic [5:0]                  status;
    logic [5:0]                  mask;
    logic [7:0]                  term;
    logic                        halt;
    logic [1:0]                  txGo;
    logic                        dpValid;
    logic                        dpWrite;
    logic [14:0]                 dpAddr;
    logic [31:0]                 rdata;
    logic                        readyOut;
    logic                        resp;
    logic                        irq;
    logic                        runLed;
  } dcu_state_s;

endpackage

/* verif/dcu_top_checker.sv */
// Port-level assertion checker for the dual channel serial unit
`timescale 1ns/1ps
module dcu_top_checker #(
  parameter int CLK_HZ = 200000000
) (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 rst_n,
  // Register bus
  input wire dcu_pkg::dcu_ahbReq_s ahbReq,
  input wire logic                 hready,
  input wire dcu_pkg::dcu_ahbRsp_s ahbRsp,
  // Serial lines
  input wire logic                 ch1Rxd,
  input wire logic                 ch2Rxd,
  input wire logic                 ch1Txd,
  input wire logic                 ch2Txd,
  // Lamps
  input wire logic                 ch1_tx_active_led,
  input wire logic                 ch2_tx_active_led,
  input wire logic                 ch1_rx_active_led,
  input wire logic                 ch2_rx_active_led
);
  import dcu_pkg::*;
  localparam int MinBit = CLK_HZ / 19200;
  logic [31:0] lowCnt_ff;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Low run length on channel 1 line
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lowCnt_ff <= 32'h0;
    end else begin
      lowCnt_ff <= ch1Txd ? 32'h0 : lowCnt_ff + 32'h1;
    end
  end
  // ==========================================================
  // Assertions
  chk_bus_okay: assert property (ahbRsp.hreadyout && !ahbRsp.hresp)
    else $error("bus slave stalled or not okay");
  chk_rdata_hold: assert property (!(hready && ahbReq.hsel && ahbReq.htrans[1])
    |=> $stable(ahbRsp.hrdata))
    else $error("read data moved without a transfer");
  chk_tx1_lamp: assert property (!ch1Txd |-> ch1_tx_active_led)
    else $error("channel 1 line low with send lamp off");
  chk_tx2_lamp: assert property (!ch2Txd |-> ch2_tx_active_led)
    else $error("channel 2 line low with send lamp off");
  chk_lamp_off_idle: assert property ($fell(ch1_tx_active_led) |-> ch1Txd)
    else $error("send lamp dropped mid character");
  chk_bit_min: assert property ($rose(ch1Txd) |-> lowCnt_ff >= 32'(MinBit))
    else $error("low level shorter than one bit");
  chk_start_hold: assert property ($fell(ch2Txd) |=> !ch2Txd [*4])
    else $error("channel 2 low level too short");
  chk_rx1_lamp: assert property ($fell(ch1Rxd) && !ch1_rx_active_led
    |-> ##[1:4] ch1_rx_active_led)
    else $error("channel 1 receive lamp late");
  chk_rx2_lamp: assert property ($fell(ch2Rxd) && !ch2_rx_active_led
    |-> ##[1:4] ch2_rx_active_led)
    else $error("channel 2 receive lamp late");
  cov_tx1: cover property ($fell(ch1Txd));
  cov_rx2: cover property ($rose(ch2_rx_active_led));
  cov_read: cover property (hready && ahbReq.htrans[1] && !ahbReq.hwrite);
endmodule

bind dcu_top dcu_top_checker #(.CLK_HZ(CLK_HZ)) chk (
  .clk(clk), .rst_n(rst_n), .ahbReq(ahbReq), .hready(hready), .ahbRsp(ahbRsp),
  .ch1Rxd(ch1Rxd), .ch2Rxd(ch2Rxd), .ch1Txd(ch1Txd), .ch2Txd(ch2Txd),
  .ch1_tx_active_led(ch1_tx_active_led), .ch2_tx_active_led(ch2_tx_active_led),
  .ch1_rx_active_led(ch1_rx_active_led), .ch2_rx_active_led(ch2_rx_active_led));

/* verif/dcu_serial_peer.sv */
// Serial equipment model at the far end of one channel
`timescale 1ns/1ps
module dcu_serial_peer (
  // Clock, bit time in cycles and parity sense
  input  wire logic        clk,
  input  wire logic [15:0] bitCyc,
  input  wire logic        parOdd,
  // Lines
  input  wire logic        devTxd,
  output      logic        devRxd,
  // Decoded character, bit 8 set when framed well
  output      logic        gotValid,
  output      logic [8:0]  gotChar
);
  logic [10:0] fr;
  logic [7:0]  d;
  logic        p;
  logic        ok;
  initial begin
    devRxd = 1'b1;
    gotValid = 1'b0;
    gotChar = 9'h0;
  end
  // ==========================================================
  // Send: start low, 8 data LSB first, parity as set, high stop
  task automatic sendChar(input logic [7:0] c);
    @(posedge clk);
    fr = {1'b1, (parOdd ? ~^c : ^c), c, 1'b0};
    for (int i = 0; i < 11; i++) begin
      devRxd <= fr[i];
      repeat (bitCyc) @(posedge clk);
    end
  endtask
  // ==========================================================
  // Receive at mid bit
  always begin
    @(negedge devTxd);
    repeat (bitCyc / 16'h2) @(posedge clk);
    ok = !devTxd;
    for (int i = 0; i < 8; i++) begin
      repeat (bitCyc) @(posedge clk);
      d[i] = devTxd;
    end
    repeat (bitCyc) @(posedge clk);
    p = devTxd;
    repeat (bitCyc) @(posedge clk);
    ok = ok && devTxd && ((^{d, p}) == parOdd);
    gotChar <= {ok, d};
    gotValid <= 1'b1;
    @(posedge clk);
    gotValid <= 1'b0;
  end
endmodule

/* verif/tb_dual_channel_ascii_message_uart.sv */
// Self-checking bench for the dual channel message serial unit
`timescale 1ns/1ps
`include "dcu_params.svh"
module tb_dual_channel_ascii_message_uart;
  import dcu_pkg::*;
  localparam int          ClkHz = 96000;
  localparam logic [31:0] aCtrl = 32'(`DCU_REG_CTRL);
  localparam logic [31:0] aStat = 32'(`DCU_REG_STATUS);
  localparam logic [31:0] aMask = 32'(`DCU_REG_MASK);
  localparam logic [31:0] aTerm = 32'(`DCU_REG_TERM);
  localparam logic [31:0] aLen0 = 32'(`DCU_REG_RXLEN0);
  localparam logic [31:0] aSw   = 32'(`DCU_REG_SWITCH);
  logic        clk, rst_n, hready, irq, run, rdChk;
  logic        rxd1, rxd2, txd1, txd2, tl1, rl1, tl2, rl2, v1, v2;
  dcu_ahbReq_s req;
  dcu_ahbRsp_s rsp;
  logic [6:0]  sw1, sw2;
  logic [15:0] bit1, bit2;
  logic [8:0]  g1, g2;
  logic [31:0] rv;
  logic [31:0] rdQ[$];
  logic [7:0]  txQ[2][$];
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          seed = 32'h1E03;
  assign hready = rsp.hreadyout;
  dcu_top #(.CLK_HZ(ClkHz)) uut (
    .clk(clk), .rst_n(rst_n), .ahbReq(req), .hready(hready), .ahbRsp(rsp), .irq(irq),
    .ch1_param_switches(sw1), .ch2_param_switches(sw2), .ch1Rxd(rxd1), .ch2Rxd(rxd2),
    .ch1Txd(txd1), .ch2Txd(txd2), .runLed(run), .ch1_tx_active_led(tl1),
    .ch1_rx_active_led(rl1), .ch2_tx_active_led(tl2), .ch2_rx_active_led(rl2));
  dcu_serial_peer p1 (.clk(clk), .bitCyc(bit1), .parOdd(sw1[4]), .devTxd(txd1),
    .devRxd(rxd1), .gotValid(v1), .gotChar(g1));
  dcu_serial_peer p2 (.clk(clk), .bitCyc(bit2), .parOdd(sw2[4]), .devTxd(txd2),
    .devRxd(rxd2), .gotValid(v2), .gotChar(g2));
  // ==========================================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    results();
  end
  // ==========================================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic waitReady();
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) begin
        n_mismatch++;
        results();
      end
      @(posedge clk);
    end
  endtask
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
                      input logic c, output logic [31:0] rd);
    @(posedge clk);
    req.htrans <= 2'h2;
    req.haddr <= a;
    req.hwrite <= w;
    waitReady();
    req.htrans <= 2'h0;
    req.hwdata <= wd;
    rdChk <= c;
    waitReady();
    rd = rsp.hrdata;
    rdChk <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d, 1'b0, rv);
  endtask
  task automatic rdExp(input logic [31:0] a, input logic [31:0] e);
    rdQ.push_back(e);
    xfer(a, 1'b0, 32'h0, 1'b1, rv);
  endtask
  task automatic pollSt(input logic [31:0] m);
    int n;
    n = 0;
    rv = 32'h0;
    while ((rv & m) !== m) begin
      n++;
      if (n > 4000) begin
        n_mismatch++;
        results();
      end
      xfer(aStat, 1'b0, 32'h0, 1'b0, rv);
    end
  endtask
  task automatic sendOn(input int ch, input logic [7:0] c);
    if (ch == 0) begin
      p1.sendChar(c);
    end else begin
      p2.sendChar(c);
    end
  endtask
  function automatic logic [7:0] letter();
    return 8'h41 + 8'($unsigned($random(seed)) % 26);
  endfunction
  // ==========================================================
  // Result monitor
  always @(posedge clk) begin
    if (rdChk) begin
      check(rsp.hrdata, rdQ.size() > 0 ? rdQ.pop_front() : 32'hX);
    end
    if (v1) begin
      check(32'(g1), {23'h1, txQ[0].size() > 0 ? txQ[0].pop_front() : 8'hXX});
    end
    if (v2) begin
      check(32'(g2), {23'h1, txQ[1].size() > 0 ? txQ[1].pop_front() : 8'hXX});
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] c;
    logic [7:0] m[4];
    req = '{1'b1, 2'h0, 32'h0, 1'b0, 3'h2, 32'h0};
    rst_n = 1'b0;
    sw1 = 7'h3D;
    sw2 = 7'h3D;
    bit1 = 16'h000A;
    bit2 = 16'h000A;
    rdChk = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check(32'({run, irq, txd1, txd2, tl1, rl1}), 32'h2C);
    rdExp(aTerm, 32'h0D);
    rdExp(aSw, {17'h0, sw2, 1'b0, sw1});
    rdExp(32'h2E00, 32'h0);
    rdExp(32'h6000, 32'h0);
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      sw1 <= {k[2], 1'b1, k[1], 1'b1, 3'(k)};
      sw2 <= {k[2], 1'b1, k[1], 1'b1, 3'(6 - k)};
      bit1 <= 16'(ClkHz / (300 << (k == 7 ? 5 : k)));
      bit2 <= 16'(ClkHz / (300 << (k == 7 ? 5 : 6 - k)));
      wr(aMask, k[0] ? 32'h0C : 32'h0);
      for (int ch = 0; ch < 2; ch++) begin
        c = letter();
        txQ[ch].push_back(c);
        txQ[ch].push_back(8'h0D);
        wr(32'h4000 + 32'(ch) * 32'h1000, {24'h0, c});
        wr(32'h4004 + 32'(ch) * 32'h1000, 32'h0D);
      end
      check(32'({tl1, tl2, txd1, txd2}), 32'h3);
      wr(aCtrl, 32'h3);
      pollSt(32'h0C);
      check(32'(irq), 32'(k[0]));
      wr(aStat, 32'h0C);
      repeat (3) @(posedge clk);
      check(32'({irq, tl1, tl2}), 32'h0);
    end
    check(32'(txQ[0].size() + txQ[1].size()), 32'h0);
    $display("test transmit done");
    wr(aTerm, 32'h2E);
    sw1 <= 7'h3E;
    sw2 <= 7'h3E;
    bit1 <= 16'h0005;
    bit2 <= 16'h0005;
    repeat (4) @(posedge clk);
    for (int ch = 0; ch < 2; ch++) begin
      m = '{letter(), 8'h0D, letter(), 8'h2E};
      for (int i = 0; i < 4; i++) begin
        sendOn(ch, m[i]);
      end
      pollSt(32'(1 << ch));
      rdExp(aLen0 + 32'(4 * ch), 32'h4);
      for (int i = 0; i < 4; i++) begin
        rdExp(32'h2000 + 32'(ch) * 32'h1000 + 32'(4 * i), {24'h0, m[i]});
      end
    end
    rdExp(aStat, 32'h3);
    $display("test receive done");
    sendOn(1, 8'h5A);
    repeat (4) @(posedge clk);
    rdExp(aStat, 32'h23);
    check(32'(run), 32'h0);
    wr(aStat, 32'h23);
    repeat (3) @(posedge clk);
    check(32'({run, rl2}), 32'h2);
    wr(aCtrl, 32'h10);
    repeat (3) @(posedge clk);
    check(32'(run), 32'h0);
    wr(aCtrl, 32'h0);
    repeat (3) @(posedge clk);
    check(32'(run), 32'h1);
    $display("test run lamp done");
    results();
  end
endmodule
